// ---- fpe_pkg.sv ----
package fpe_pkg;

  // Register offsets inside register bank 1.
  localparam logic [7:0] FPE_OFS_MODE_CTRL = 8'hf5;
  localparam logic [7:0] FPE_OFS_UNLOCK = 8'hf6;
  localparam logic [7:0] FPE_OFS_SEC_HIGH = 8'hf7;
  localparam logic [7:0] FPE_OFS_SEC_LOW = 8'hf8;
  localparam logic FPE_BANK_SEL = 1'b1;

  // Field layout of the mode control and low sector pointer registers.
  localparam int FPE_MODE_MSB = 7;
  localparam int FPE_MODE_LSB = 4;
  localparam int FPE_FAIL_BIT = 3;
  localparam int FPE_START_BIT = 0;
  localparam int FPE_SEC_LOW_BIT = 7;

  // Mode selector codes and the unlock pattern.
  localparam logic [3:0] FPE_CODE_PROG = 4'h5;
  localparam logic [3:0] FPE_CODE_ERASE = 4'ha;
  localparam logic [3:0] FPE_CODE_LOCK = 4'h6;
  localparam logic [7:0] FPE_UNLOCK_KEY = 8'ha5;

  localparam logic [3:0] FPE_MODE_RST = 4'h0;
  localparam logic [7:0] FPE_BYTE_RST = 8'h00;
  localparam logic [6:0] FPE_SEC_PAD = 7'h00;

  typedef enum logic [1:0] {
    FPE_OP_NONE = 2'h0,
    FPE_OP_PROG = 2'h1,
    FPE_OP_ERASE = 2'h2,
    FPE_OP_LOCK = 2'h3
  } fpe_op_e;

  typedef enum logic [1:0] {
    FPE_ST_IDLE = 2'h0,
    FPE_ST_WAIT = 2'h1,
    FPE_ST_DONE = 2'h3
  } fpe_state_e;

  // Command presented to the flash array.
  typedef struct packed {
    logic go;
    fpe_op_e op;
    logic [15:0] addr;
  } fpe_flash_cmd_s;

  // Register access strobe group.
  typedef struct packed {
    logic bank;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } fpe_reg_req_s;

  function automatic fpe_op_e fpe_decode_mode(input logic [3:0] code);
    fpe_op_e op;
    op = FPE_OP_NONE;
    unique case (code)
      FPE_CODE_PROG: op = FPE_OP_PROG;
      FPE_CODE_ERASE: op = FPE_OP_ERASE;
      FPE_CODE_LOCK: op = FPE_OP_LOCK;
      default: op = FPE_OP_NONE;
    endcase
    return op;
  endfunction : fpe_decode_mode

endpackage : fpe_pkg

// ---- fpe_seq.sv ----
`timescale 1ns/1ps
`default_nettype none

module fpe_seq
  import fpe_pkg::*;
(
  input wire logic clock_i, // System clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic launch_i, // One-cycle request to start an operation.
  input wire fpe_op_e op_i, // Operation to run.
  input wire logic [15:0] addr_i, // Sector pointer.
  input wire logic flash_done_i, // Array reports completion.
  input wire logic flash_fail_i, // Array reports failure with done.
  output fpe_flash_cmd_s cmd_o, // Command to the array.
  output logic done_o, // One-cycle completion pulse.
  output logic fail_o // Failure of the finished operation.
);

  fpe_state_e state;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= FPE_ST_IDLE;
    end else begin
      unique case (state)
        FPE_ST_IDLE: if (launch_i) state <= FPE_ST_WAIT;
        FPE_ST_WAIT: if (flash_done_i) state <= FPE_ST_DONE;
        FPE_ST_DONE: state <= FPE_ST_IDLE;
        default: state <= FPE_ST_IDLE;
      endcase
    end
  end

  // Op and address stay on the bus for the whole operation; go is a single pulse.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_o <= '0;
    end else begin
      cmd_o.go <= launch_i && (state == FPE_ST_IDLE);
      if (launch_i && (state == FPE_ST_IDLE)) begin
        cmd_o.op <= op_i;
        cmd_o.addr <= addr_i;
      end else if (state == FPE_ST_DONE) begin
        cmd_o.op <= FPE_OP_NONE;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      fail_o <= 1'b0;
    end else begin
      done_o <= (state == FPE_ST_WAIT) && flash_done_i;
      if ((state == FPE_ST_WAIT) && flash_done_i) fail_o <= flash_fail_i;
    end
  end

endmodule : fpe_seq

`default_nettype wire

// ---- fpe_flash_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

// How it works
// - The top four bits of the mode control register select programming, erase or lock, and any other code selects nothing.
// - Writing one to bit zero starts the selected operation and hardware clears it when the operation completes.
// - User programming is enabled only while the unlock register holds the one unlock pattern.
// - The high sector pointer byte forms address bits fifteen to eight.
// - Bit seven of the low sector pointer byte forms address bit seven and its bits six to zero are ignored.
module fpe_flash_ctrl
  import fpe_pkg::*;
(
  input wire logic clock_i, // System clock, 10 MHz.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire fpe_reg_req_s reg_req_i, // Register access from the core.
  output logic [7:0] reg_rdata_o, // Read data, one cycle after rd.
  output fpe_flash_cmd_s flash_cmd_o, // Command to the flash array.
  input wire logic flash_done_i, // Array completion pulse.
  input wire logic flash_fail_i, // Array failure, valid with done.
  output logic prog_enable_o // User programming mode enabled.
);

  logic [3:0] mode_code;
  logic start_bit;
  logic erase_fail;
  logic [7:0] unlock;
  logic [7:0] sec_high;
  logic [7:0] sec_low;
  logic seq_done;
  logic seq_fail;
  logic wr_mode;
  logic unlocked;
  logic launch;
  fpe_op_e sel_op;
  logic [15:0] sec_addr;

  function automatic logic hit(input fpe_reg_req_s r, input logic [7:0] ofs);
    return r.bank == FPE_BANK_SEL && r.addr == ofs;
  endfunction : hit

  assign wr_mode = reg_req_i.wr && hit(reg_req_i, FPE_OFS_MODE_CTRL);
  assign unlocked = (unlock == FPE_UNLOCK_KEY);
  assign sel_op = fpe_decode_mode(reg_req_i.wdata[FPE_MODE_MSB:FPE_MODE_LSB]);
  // A start needs the key, a usable code and an idle sequencer.
  assign launch = wr_mode && reg_req_i.wdata[FPE_START_BIT] && unlocked
                  && (sel_op != FPE_OP_NONE) && !start_bit;
  assign sec_addr = {sec_high, sec_low[FPE_SEC_LOW_BIT], FPE_SEC_PAD};

  // Mode bits are frozen while an operation runs so a read shows the selector of the running operation.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mode_code <= FPE_MODE_RST;
    end else if (wr_mode && !start_bit) begin
      mode_code <= reg_req_i.wdata[FPE_MODE_MSB:FPE_MODE_LSB];
    end
  end

  // Start bit cannot be cleared by software; an operation in flight is not abortable.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      start_bit <= 1'b0;
    end else if (launch) begin
      start_bit <= 1'b1;
    end else if (seq_done) begin
      start_bit <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      erase_fail <= 1'b0;
    end else if (seq_done && flash_cmd_o.op == FPE_OP_ERASE) begin
      erase_fail <= seq_fail;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      unlock <= FPE_BYTE_RST;
      sec_high <= FPE_BYTE_RST;
      sec_low <= FPE_BYTE_RST;
    end else if (reg_req_i.wr) begin
      if (hit(reg_req_i, FPE_OFS_UNLOCK)) unlock <= reg_req_i.wdata;
      if (hit(reg_req_i, FPE_OFS_SEC_HIGH)) sec_high <= reg_req_i.wdata;
      if (hit(reg_req_i, FPE_OFS_SEC_LOW)) sec_low <= reg_req_i.wdata;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prog_enable_o <= 1'b0;
    end else begin
      prog_enable_o <= unlocked;
    end
  end

  // Unmapped offsets read as zero.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= FPE_BYTE_RST;
    end else if (reg_req_i.rd) begin
      if (hit(reg_req_i, FPE_OFS_MODE_CTRL)) begin
        reg_rdata_o <= {mode_code, erase_fail, 2'b00, start_bit};
      end else if (hit(reg_req_i, FPE_OFS_UNLOCK)) begin
        reg_rdata_o <= unlock;
      end else if (hit(reg_req_i, FPE_OFS_SEC_HIGH)) begin
        reg_rdata_o <= sec_high;
      end else if (hit(reg_req_i, FPE_OFS_SEC_LOW)) begin
        reg_rdata_o <= sec_low;
      end else begin
        reg_rdata_o <= FPE_BYTE_RST;
      end
    end
  end

  fpe_seq u_seq (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .launch_i(launch),
    .op_i(sel_op),
    .addr_i(sec_addr),
    .flash_done_i(flash_done_i),
    .flash_fail_i(flash_fail_i),
    .cmd_o(flash_cmd_o),
    .done_o(seq_done),
    .fail_o(seq_fail)
  );

  a_launch_go_pulse: assert property (
    @(posedge clock_i) disable iff (rst_i)
    launch |=> flash_cmd_o.go && start_bit ##1 !flash_cmd_o.go)
    else $error("accepted start did not give one go pulse");

  a_no_key_ignored: assert property (
    @(posedge clock_i) disable iff (rst_i)
    wr_mode && !start_bit && !unlocked |=> !start_bit && !flash_cmd_o.go)
    else $error("start taken without unlock pattern");

  a_bad_code_ignored: assert property (
    @(posedge clock_i) disable iff (rst_i)
    wr_mode && !start_bit && sel_op == FPE_OP_NONE |=> !flash_cmd_o.go)
    else $error("start taken with unavailable mode code");

  a_op_matches_mode: assert property (
    @(posedge clock_i) disable iff (rst_i)
    flash_cmd_o.go |-> flash_cmd_o.op == fpe_decode_mode(mode_code)
                       && flash_cmd_o.op != FPE_OP_NONE)
    else $error("flash op differs from mode selector");

  a_key_before_go: assert property (
    @(posedge clock_i) disable iff (rst_i)
    $rose(start_bit) |-> $past(unlock) == FPE_UNLOCK_KEY)
    else $error("operation started while locked");

  a_addr_high_byte: assert property (
    @(posedge clock_i) disable iff (rst_i)
    flash_cmd_o.go |-> flash_cmd_o.addr[15:8] == $past(sec_high))
    else $error("sector high byte not on address");

  a_addr_low_bit: assert property (
    @(posedge clock_i) disable iff (rst_i)
    flash_cmd_o.go |-> flash_cmd_o.addr[7] == $past(sec_low[FPE_SEC_LOW_BIT])
                       && flash_cmd_o.addr[6:0] == FPE_SEC_PAD)
    else $error("sector low bits wrong on address");

  a_start_self_clear: assert property (
    @(posedge clock_i) disable iff (rst_i)
    start_bit && !flash_cmd_o.go && flash_done_i |=> start_bit ##1 !start_bit)
    else $error("start bit not cleared two cycles after done");

  a_erase_fail_flag: assert property (
    @(posedge clock_i) disable iff (rst_i)
    seq_done && flash_cmd_o.op == FPE_OP_ERASE |=> erase_fail == $past(seq_fail))
    else $error("erase status not updated");

  // Side effects below are checked by the tests at a few points only, so they are watched here in every cycle.
  a_fail_flag_kept: assert property (
    @(posedge clock_i) disable iff (rst_i)
    !(seq_done && flash_cmd_o.op == FPE_OP_ERASE) |=> $stable(erase_fail))
    else $error("erase status changed outside an erase end");

  a_unlock_level: assert property (
    @(posedge clock_i) disable iff (rst_i)
    1'b1 |=> prog_enable_o == ($past(unlock) == FPE_UNLOCK_KEY))
    else $error("programming enable does not follow unlock register");

  a_mode_frozen: assert property (
    @(posedge clock_i) disable iff (rst_i)
    start_bit |=> $stable(mode_code))
    else $error("mode selector changed while busy");

  a_go_only_busy: assert property (
    @(posedge clock_i) disable iff (rst_i)
    flash_cmd_o.go |-> start_bit)
    else $error("go issued without start bit");

  a_no_relaunch: assert property (
    @(posedge clock_i) disable iff (rst_i)
    start_bit && !flash_cmd_o.go |=> !flash_cmd_o.go)
    else $error("second go while operation runs");

  a_op_clear: assert property (
    @(posedge clock_i) disable iff (rst_i)
    $fell(start_bit) |-> flash_cmd_o.op == FPE_OP_NONE)
    else $error("flash op not idle after completion");

  a_pad_bits_zero: assert property (
    @(posedge clock_i) disable iff (rst_i)
    flash_cmd_o.addr[6:0] == FPE_SEC_PAD)
    else $error("ignored low pointer bits reached the address");

  a_high_byte_write: assert property (
    @(posedge clock_i) disable iff (rst_i)
    reg_req_i.wr && hit(reg_req_i, FPE_OFS_SEC_HIGH) |=> sec_high == $past(reg_req_i.wdata))
    else $error("sector high byte write lost");

  a_rdata_bank_zero: assert property (
    @(posedge clock_i) disable iff (rst_i)
    reg_req_i.rd && reg_req_i.bank != FPE_BANK_SEL |=> reg_rdata_o == FPE_BYTE_RST)
    else $error("read outside the bank did not return zero");

endmodule : fpe_flash_ctrl

`default_nettype wire

// ---- fpe_flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module fpe_flash_model
  import fpe_pkg::*;
#(
  parameter int DLY = 4
)
(
  input wire logic clock_i, // System clock.
  input wire logic rst_i, // Reset, active high.
  input wire fpe_flash_cmd_s cmd_i, // Command from the sequencer.
  input wire logic fail_mode_i, // Report failure on completion.
  output logic done_o, // Completion pulse.
  output logic fail_o // Failure, valid with done only.
);
  int cnt;
  logic busy;
  logic tog;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      cnt <= 0;
      done_o <= 1'b0;
      tog <= 1'b0;
    end else begin
      tog <= ~tog;
      done_o <= 1'b0;
      if (cmd_i.go) begin
        busy <= 1'b1;
        cnt <= DLY;
      end else if (busy) begin
        if (cnt == 0) begin
          busy <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt <= cnt - 1;
        end
      end
    end
  end

  // Outside the done pulse the failure line carries noise, never a stale value.
  assign fail_o = done_o ? fail_mode_i : tog;
endmodule : fpe_flash_model

`default_nettype wire

// ---- flash_program_erase_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module flash_program_erase_control_tb;
  import fpe_pkg::*;
  logic clock_i;
  logic rst_i;
  fpe_reg_req_s req;
  logic [7:0] rdata;
  fpe_flash_cmd_s cmd;
  logic fdone;
  logic ffail;
  logic fail_mode;
  logic pen;
  logic fail_bit;
  int n_errors;
  int tests_run;
  logic [3:0] codes [4] = '{4'h5, 4'h6, 4'ha, 4'ha};
  logic [1:0] ops [4] = '{2'h1, 2'h3, 2'h2, 2'h2};
  logic fails [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  logic [7:0] ends [4] = '{8'h50, 8'h60, 8'ha8, 8'ha0};

  fpe_flash_ctrl i_dut (.clock_i(clock_i), .rst_i(rst_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .flash_cmd_o(cmd), .flash_done_i(fdone),
    .flash_fail_i(ffail), .prog_enable_o(pen));
  fpe_flash_model #(.DLY(4)) i_mem (.clock_i(clock_i), .rst_i(rst_i), .cmd_i(cmd),
    .fail_mode_i(fail_mode), .done_o(fdone), .fail_o(ffail));

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic cyc();
    @(posedge clock_i);
    #10;
  endtask : cyc

  // Each access first lets one edge pass, so a strobe is never lowered and raised in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc();
    req = '{bank: 1'b1, addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    cyc();
    req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic b, input logic [7:0] a, input logic [7:0] exp);
    cyc();
    req = '{bank: b, addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    cyc();
    req.rd = 1'b0;
    check($sformatf("read %h", a), {8'h00, rdata}, {8'h00, exp});
  endtask : rd

  task automatic report_and_stop();
    $display("tests %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    n_errors = 0;
    tests_run = 0;
    req = '0;
    fail_mode = 1'b0;
    fail_bit = 1'b0;
    rst_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #10;
    rst_i = 1'b0;
    rd(1'b1, FPE_OFS_MODE_CTRL, 8'h00);
    rd(1'b1, FPE_OFS_UNLOCK, 8'h00);
    rd(1'b1, FPE_OFS_SEC_HIGH, 8'h00);
    rd(1'b1, FPE_OFS_SEC_LOW, 8'h00);
    rd(1'b1, 8'h10, 8'h00);
    $display("test reset done");
    // The key must match in every bit; a4 differs from it in the lowest bit only.
    wr(FPE_OFS_UNLOCK, 8'ha4);
    cyc();
    check("prog_enable", {15'h0, pen}, 16'h0000);
    wr(FPE_OFS_UNLOCK, FPE_UNLOCK_KEY);
    cyc();
    check("prog_enable", {15'h0, pen}, 16'h0001);
    rd(1'b0, FPE_OFS_UNLOCK, 8'h00);
    wr(FPE_OFS_SEC_LOW, 8'hff);
    rd(1'b1, FPE_OFS_SEC_LOW, 8'hff);
    $display("test unlock done");
    for (int i = 0; i < 4; i++) begin
      fail_mode = fails[i];
      wr(FPE_OFS_SEC_HIGH, 8'h10 + 8'(i));
      wr(FPE_OFS_MODE_CTRL, {codes[i], 4'h1});
      check("go", {15'h0, cmd.go}, 16'h0001);
      check("op", {14'h0, cmd.op}, {14'h0, ops[i]});
      check("addr", cmd.addr, {8'h10 + 8'(i), 8'h80});
      rd(1'b1, FPE_OFS_MODE_CTRL, {codes[i], fail_bit, 3'h1});
      check("go pulse", {15'h0, cmd.go}, 16'h0000);
      wr(FPE_OFS_MODE_CTRL, 8'ha1);
      check("go busy", {15'h0, cmd.go}, 16'h0000);
      for (int k = 0; k < 50 && fdone !== 1'b1; k++) cyc();
      repeat (3) cyc();
      rd(1'b1, FPE_OFS_MODE_CTRL, ends[i]);
      check("op idle", {14'h0, cmd.op}, 16'h0000);
      fail_bit = ends[i][FPE_FAIL_BIT];
    end
    $display("test operations done");
    wr(FPE_OFS_MODE_CTRL, 8'h31);
    check("go bad code", {15'h0, cmd.go}, 16'h0000);
    rd(1'b1, FPE_OFS_MODE_CTRL, 8'h30);
    wr(FPE_OFS_UNLOCK, 8'h00);
    cyc();
    check("prog_enable", {15'h0, pen}, 16'h0000);
    wr(FPE_OFS_MODE_CTRL, 8'h51);
    check("go locked", {15'h0, cmd.go}, 16'h0000);
    rd(1'b1, FPE_OFS_MODE_CTRL, 8'h50);
    $display("test refusals done");
    wr(FPE_OFS_UNLOCK, FPE_UNLOCK_KEY);
    wr(FPE_OFS_MODE_CTRL, 8'h61);
    check("go before reset", {15'h0, cmd.go}, 16'h0001);
    rst_i = 1'b1;
    repeat (2) cyc();
    rst_i = 1'b0;
    check("op after reset", {14'h0, cmd.op}, 16'h0000);
    check("prog_enable", {15'h0, pen}, 16'h0000);
    rd(1'b1, FPE_OFS_MODE_CTRL, 8'h00);
    rd(1'b1, FPE_OFS_UNLOCK, 8'h00);
    $display("test mid reset done");
    report_and_stop();
  end
endmodule : flash_program_erase_control_tb

`default_nettype wire
